// *** dv/sffs_chk.sv ***
// port assertions for the serial frame format block
`timescale 1ns/10ps
module sffs_chk
(
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [31:0] hwdata,
  input wire logic        hready,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic [31:0] hrdata,
  input wire logic        standby,
  input wire logic        txd,
  input wire logic        sck,
  input wire logic        irq
);
  logic rd_a;
  logic wr_a;
  logic wq;
  logic sync_q;
  assign rd_a = hsel && hready && htrans == sffs_pkg::HTRANS_NONSEQ
                && !hwrite;
  assign wr_a = hsel && hready && htrans == sffs_pkg::HTRANS_NONSEQ
                && hwrite && haddr[7:0] == sffs_pkg::OFS_FFC;
  // tracks the mode bit as software writes it
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
    begin
      wq     <= 1'b0;
      sync_q <= 1'b0;
    end
    else
    begin
      wq <= wr_a;
      if (standby)
        sync_q <= 1'b0;
      else if (wq)
        sync_q <= hwdata[7];
    end
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  a_ready_high: assert property (hreadyout)
    else $error("hreadyout low");
  a_resp_okay: assert property (hresp == sffs_pkg::HRESP_OKAY)
    else $error("hresp not okay");
  a_upper_zero: assert property (hrdata[31:9] == 23'h0)
    else $error("hrdata upper bits set");
  a_reset_idle: assert property ($rose(hresetn) |-> txd && sck && !irq
    && hrdata == 32'h0) else $error("outputs not idle after reset");
  a_standby_idle: assert property (standby
    |-> ##2 txd && sck && !irq) else $error("standby left frame state");
  a_standby_read: assert property ($fell(standby) && rd_a
    && haddr[7:0] == sffs_pkg::OFS_FFC |=> hrdata == 32'h0)
    else $error("mode register not cleared by standby");
  a_async_sck: assert property (!sync_q && !$past(sync_q) |-> sck)
    else $error("clock toggles in async mode");
  a_hold_data: assert property (!$past(rd_a) && !$past(standby)
    |-> $stable(hrdata)) else $error("hrdata changed without read");
  c_sync: cover property (sync_q && $fell(sck));
  c_irq: cover property ($rose(irq));
  c_standby: cover property ($fell(standby) && rd_a);
endmodule
bind sffs_top sffs_chk u_chk (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
  .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata),
  .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
  .standby(standby), .txd(txd), .sck(sck), .irq(irq));

// *** dv/sffs_peer.sv ***
// remote serial peer: drives rxd frames and captures txd
`timescale 1ns/10ps
module sffs_peer
(
  input  wire logic hclk,
  input  wire logic txd,
  input  wire logic sck,
  output logic      rxd
);
  logic [31:0] got;
  initial rxd = 1'b1;
  // lsb first, per cycles a bit, then the pulled-up idle level
  task automatic send(input logic [31:0] b, input int n, input int per);
    for (int i = 0; i < n; i++)
      repeat (per) @(posedge hclk) rxd <= b[i];
    @(posedge hclk) rxd <= 1'b1;
  endtask
  // start on txd low, or sck low when synchronous; sample mid-bit
  task automatic grab(input logic sync, input int n, input int per);
    int t;
    got = '1;
    t = 0;
    while ((sync ? sck : txd) === 1'b1 && t < 4000)
    begin
      @(posedge hclk);
      t++;
    end
    repeat (per / 2) @(posedge hclk);
    for (int i = 0; i < n; i++)
    begin
      got[i] = txd;
      repeat (per) @(posedge hclk);
    end
  endtask
endmodule

// *** dv/test_serial_frame_format_select.sv ***
// self-checking bench for the serial frame format block
`timescale 1ns/10ps
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin \
  errors++; $display("MISMATCH %s exp %h got %h", n, e, g); end end
module test_serial_frame_format_select;
  logic        hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
  logic        standby, sub_mode, subclk_tick, rxd, txd, sck, irq;
  logic [31:0] haddr, hwdata, hrdata, r, eb, e2;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [7:0]  rnd;
  logic [1:0]  sc;
  int          errors, samples_checked, cyc, n, t;
  logic [7:0]  fmt [8] = '{8'h00, 8'h08, 8'h20, 8'h38, 8'h24, 8'h04,
                           8'h40, 8'hb8};
  logic [1:0]  cks [5] = '{2'b00, 2'b10, 2'b11, 2'b01, 2'b01};
  int          low [5] = '{2, 32, 128, 12, 6};
  assign hready = hreadyout;
  sffs_top u_sffs_top (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .standby(standby),
    .sub_mode(sub_mode), .subclk_tick(subclk_tick), .rxd(rxd),
    .txd(txd), .sck(sck), .irq(irq));
  sffs_peer u_sffs_peer (.hclk(hclk), .txd(txd), .sck(sck), .rxd(rxd));
  function automatic logic [7:0] nxt(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  // expected line bits of one transmitted character
  function automatic int frame(input logic [7:0] f, input logic [8:0] d,
                               output logic [31:0] b);
    int   nd;
    logic p;
    b = '1;
    if (f[7])
    begin
      b[7:0] = d[7:0];
      return 8;
    end
    nd = (f[5] && f[2]) ? 5 : (f[6] ? 7 : 8);
    p = f[4] ^ (^(d[7:0] & 8'((1 << nd) - 1)));
    b[0] = 1'b0;
    for (int i = 0; i < nd; i++)
      b[i + 1] = d[i];
    if (f[5] || f[2])
      b[nd + 1] = f[5] ? p : d[8];
    return nd + 2 + int'(f[5] || f[2]) + int'(f[3]);
  endfunction
  task automatic bus(input logic [7:0] a, input logic w,
                     input logic [31:0] d);
    haddr  <= {24'h0, a};
    hwrite <= w;
    htrans <= sffs_pkg::HTRANS_NONSEQ;
    do @(posedge hclk); while (hready !== 1'b1);
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge hclk); while (hready !== 1'b1);
    r = hrdata;
  endtask
  task automatic idle_wait;
    do bus(sffs_pkg::OFS_BUSY, 1'b0, 32'h0); while (r[0] !== 1'b0);
  endtask
  task automatic lvl(input logic v);
    t = 0;
    while (txd === v && t < 3000)
    begin
      @(posedge hclk);
      t++;
    end
  endtask
  task automatic final_report;
    if (errors == 0 && samples_checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  initial
  begin
    hclk = 1'b0;
    forever #10 hclk = ~hclk;
  end
  always @(posedge hclk)
  begin
    sc <= (sc == 2'd2) ? 2'd0 : sc + 2'd1;
    subclk_tick <= (sc == 2'd2);
    cyc++;
    if (cyc == 20000)
    begin
      errors++;
      final_report;
    end
  end
  initial
  begin
    {hsel, hwrite, standby, sub_mode, subclk_tick, hresetn} = 6'h20;
    {haddr, hwdata, htrans, sc} = '0;
    hsize = 3'b010;
    rnd = 8'h38;
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    bus(sffs_pkg::OFS_FFC, 1'b0, 32'h0);
    `CHK("ffc reset", 32'h0, r)
    bus(8'h1c, 1'b0, 32'h0);
    `CHK("unmapped", 32'h0, r)
    rnd = nxt(rnd);
    bus(sffs_pkg::OFS_FFC, 1'b1, {24'h0, rnd});
    bus(sffs_pkg::OFS_FFC, 1'b0, 32'h0);
    `CHK("ffc rw", {24'h0, rnd}, r)
    standby <= 1'b1;
    @(posedge hclk);
    standby <= 1'b0;
    bus(sffs_pkg::OFS_FFC, 1'b0, 32'h0);
    `CHK("ffc standby", 32'h0, r)
    bus(sffs_pkg::OFS_MASK, 1'b1, 32'h1);
    foreach (fmt[k])
    begin
      rnd = nxt(rnd);
      bus(sffs_pkg::OFS_FFC, 1'b1, {24'h0, fmt[k]});
      n = frame(fmt[k], {rnd[0], rnd}, eb);
      bus(sffs_pkg::OFS_TXD, 1'b1, {23'h0, rnd[0], rnd});
      u_sffs_peer.grab(fmt[k][7], n, 16);
      `CHK("tx frame", eb, u_sffs_peer.got)
      idle_wait();
      `CHK("irq set", 1'b1, irq)
      bus(sffs_pkg::OFS_STAT, 1'b0, 32'h0);
      `CHK("irq clear", 1'b0, irq)
    end
    bus(sffs_pkg::OFS_RXD, 1'b0, 32'h0);
    `CHK("sync rx", 32'hff, r)
    bus(sffs_pkg::OFS_FFC, 1'b1, 32'h20);
    for (int k = 0; k < 2; k++)
    begin
      rnd = nxt(rnd);
      n = frame(8'h20, {1'b0, rnd}, eb);
      eb[9] = eb[9] ^ k[0];
      u_sffs_peer.send(eb, n, 16);
      bus(sffs_pkg::OFS_RXD, 1'b0, 32'h0);
      `CHK("rx data", {24'h0, rnd}, r)
      bus(sffs_pkg::OFS_STAT, 1'b0, 32'h0);
      `CHK("rx stat", (k == 1) ? 32'h6 : 32'h2, r)
    end
    bus(sffs_pkg::OFS_FFC, 1'b1, 32'h08);
    n = frame(8'h00, 9'h0c3, eb);
    n = frame(8'h00, 9'h03c, e2);
    u_sffs_peer.send({12'hfff, e2[9:0], eb[9:0]}, 20, 16);
    bus(sffs_pkg::OFS_RXD, 1'b0, 32'h0);
    `CHK("rx second", 32'h3c, r)
    bus(sffs_pkg::OFS_STAT, 1'b0, 32'h0);
    `CHK("rx stop", 32'h2, r)
    eb[9] = 1'b0;
    u_sffs_peer.send(eb, 10, 16);
    bus(sffs_pkg::OFS_STAT, 1'b0, 32'h0);
    `CHK("frame err", 1'b1, r[3])
    bus(sffs_pkg::OFS_PERIOD, 1'b1, 32'h2);
    bus(sffs_pkg::OFS_MASK, 1'b1, 32'h0);
    for (int c = 0; c < 5; c++)
    begin
      sub_mode <= (c == 4);
      bus(sffs_pkg::OFS_FFC, 1'b1, {30'h0, cks[c]});
      bus(sffs_pkg::OFS_TXD, 1'b1, 32'h1);
      lvl(1'b1);
      lvl(1'b0);
      lvl(1'b1);
      `CHK("bit time", low[c], t)
      idle_wait();
      `CHK("irq masked", 1'b0, irq)
    end
    final_report;
  end
endmodule

// *** verilog/sffs_baud_src.sv ***
// prescaler feeding the baud rate generator
`timescale 1ns/10ps
module sffs_baud_src
(
  input  wire logic       hclk,
  input  wire logic       hresetn,
  input  wire logic [1:0] sel,
  input  wire logic       sub_mode,
  input  wire logic       subclk_tick,
  output logic            src_tick
);
  logic [5:0] div_reg;
  logic       half_reg;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      div_reg <= 6'h00;
    else
      div_reg <= div_reg + 6'h01;
  end

  // halves the subclock outside the subclock-run modes
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      half_reg <= 1'b0;
    else if (subclk_tick)
      half_reg <= ~half_reg;
  end

  always_comb
  begin
    unique case (sel)
      sffs_pkg::CKS_SYS:   src_tick = 1'b1;
      sffs_pkg::CKS_SUB:   src_tick = subclk_tick & (sub_mode | half_reg);
      sffs_pkg::CKS_DIV16:
        src_tick = (div_reg & sffs_pkg::DIV16_MASK) == sffs_pkg::DIV16_MASK;
      sffs_pkg::CKS_DIV64: src_tick = div_reg == sffs_pkg::DIV64_MASK;
    endcase
  end
endmodule

// *** verilog/sffs_pkg.sv ***
// constants for the serial frame format block
package sffs_pkg;
  localparam logic [7:0] OFS_FFC    = 8'h00;
  localparam logic [7:0] OFS_PERIOD = 8'h04;
  localparam logic [7:0] OFS_TXD    = 8'h08;
  localparam logic [7:0] OFS_RXD    = 8'h0c;
  localparam logic [7:0] OFS_STAT   = 8'h10;
  localparam logic [7:0] OFS_MASK   = 8'h14;
  localparam logic [7:0] OFS_BUSY   = 8'h18;
  localparam int BIT_COM   = 7;
  localparam int BIT_CHR   = 6;
  localparam int BIT_PE    = 5;
  localparam int BIT_PM    = 4;
  localparam int BIT_STOP  = 3;
  localparam int BIT_MP    = 2;
  localparam int BIT_CKSHI = 1;
  localparam int BIT_CKSLO = 0;
  localparam logic [7:0] FFC_RESET    = 8'h00;
  localparam logic [7:0] PERIOD_RESET = 8'h10;
  localparam logic [8:0] TXD_RESET    = 9'h1ff;
  localparam logic [3:0] IRQ_RESET    = 4'h0;
  localparam int EV_TXDONE = 0;
  localparam int EV_RXFULL = 1;
  localparam int EV_PARERR = 2;
  localparam int EV_FRMERR = 3;
  localparam int NEV       = 4;
  localparam logic [1:0] CKS_SYS   = 2'b00;
  localparam logic [1:0] CKS_SUB   = 2'b01;
  localparam logic [1:0] CKS_DIV16 = 2'b10;
  localparam logic [1:0] CKS_DIV64 = 2'b11;
  localparam logic [5:0] DIV16_MASK = 6'h0f;
  localparam logic [5:0] DIV64_MASK = 6'h3f;
  localparam int FRAME_MAX = 13;
  localparam logic [1:0] HTRANS_NONSEQ = 2'b10;
  localparam logic       HRESP_OKAY    = 1'b0;
  typedef enum logic {RX_IDLE, RX_BITS} sffs_rx_type;
endpackage

// *** verilog/sffs_top.sv ***
// serial frame format block with ahb-lite register slave
`timescale 1ns/10ps
// Overview of operation
// - synchronous mode: no parity added or checked
// - async parity enable adds and checks parity
// - parity sense even at 0, odd at 1
// - parity makes total ones even or odd
// - async transmit sends one or two stops
// - receive checks only the first stop bit
// - synchronous mode sends no stop bits
// - multiprocessor bit only in async mode
// - clock source: sys, sub, /16, /64
// - subclock halved except in subclock modes
// - mode bit: async at 0, synchronous at 1
// - async parity plus multiprocessor gives 5-bit characters
// - mode register clears on reset and standby
module sffs_top
#(
  parameter int PERIOD_W = 8
)
(
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  input  wire logic        standby,
  input  wire logic        sub_mode,
  input  wire logic        subclk_tick,
  input  wire logic        rxd,
  output logic             txd,
  output logic             sck,
  output logic             irq
);
  localparam int FRAME_W = sffs_pkg::FRAME_MAX;
  typedef sffs_pkg::sffs_rx_type sffs_rx_type;

  if (PERIOD_W < 2 || PERIOD_W > 24)
  begin
    $error("PERIOD_W out of range");
  end

  logic [7:0]          ffc_reg;
  logic [PERIOD_W-1:0] period_reg;
  logic [8:0]          txh_reg;
  logic [8:0]          rxd_reg;
  logic [3:0]          stat_reg;
  logic [3:0]          stat_next;
  logic [3:0]          mask_reg;
  logic [7:0]          addr_reg;
  logic                wr_reg;
  logic [31:0]         hrdata_reg;
  logic [FRAME_W-1:0]  tx_sh_reg;
  logic [3:0]          tx_left_reg;
  logic [PERIOD_W-1:0] tx_cnt_reg;
  logic                tx_busy_reg;
  logic                txd_reg;
  logic                sck_reg;
  sffs_rx_type         rx_state_reg;
  logic [PERIOD_W-1:0] rx_cnt_reg;
  logic [3:0]          rx_idx_reg;
  logic [9:0]          rx_sh_reg;
  logic                src_tick;
  logic                addr_ok;
  logic                wr_go;
  logic                tx_load;
  logic                tx_tick;
  logic                rx_tick;
  logic                rx_last;
  logic [3:0]          ev;

  // data bits per character
  function automatic logic [3:0] nbits(input logic [7:0] f);
    if (f[sffs_pkg::BIT_COM])
      return 4'd8;
    else if (f[sffs_pkg::BIT_PE] & f[sffs_pkg::BIT_MP])
      return 4'd5;
    else if (f[sffs_pkg::BIT_CHR])
      return 4'd7;
    return 4'd8;
  endfunction

  // parity in use only in asynchronous mode
  function automatic logic par_on(input logic [7:0] f);
    return ~f[sffs_pkg::BIT_COM] & f[sffs_pkg::BIT_PE];
  endfunction

  // multiprocessor bit in use only in asynchronous mode
  function automatic logic mpb_on(input logic [7:0] f);
    return ~f[sffs_pkg::BIT_COM] & f[sffs_pkg::BIT_MP]
           & ~f[sffs_pkg::BIT_PE];
  endfunction

  // parity bit over the active data bits
  function automatic logic par_bit(input logic [7:0] f,
                                   input logic [7:0] d);
    logic [7:0] m;
    m = d & ((8'h01 << nbits(f)) - 8'h01);
    return (^m) ^ f[sffs_pkg::BIT_PM];
  endfunction

  // builds the line bits, lsb first, idle ones beyond
  function automatic logic [FRAME_W-1:0] frame(input logic [7:0] f,
                                               input logic [8:0] d);
    logic [FRAME_W-1:0] v;
    int p;
    v = '1;
    p = 0;
    if (!f[sffs_pkg::BIT_COM])
    begin
      v[0] = 1'b0;
      p = 1;
    end
    for (int i = 0; i < 8; i++)
      if (i < int'(nbits(f)))
        v[p+i] = d[i];
    p = p + int'(nbits(f));
    if (par_on(f))
      v[p] = par_bit(f, d[7:0]);
    if (mpb_on(f))
      v[p] = d[8];
    return v;
  endfunction

  // bits on the line; stop bits remain in the idle ones
  function automatic logic [3:0] flen(input logic [7:0] f);
    logic [3:0] n;
    n = nbits(f) + {3'b000, par_on(f) | mpb_on(f)};
    if (f[sffs_pkg::BIT_COM])
      return n;
    return n + (f[sffs_pkg::BIT_STOP] ? 4'd3 : 4'd2);
  endfunction

  sffs_baud_src u_baud
  (
    .hclk        (hclk),
    .hresetn     (hresetn),
    .sel         (ffc_reg[sffs_pkg::BIT_CKSHI:sffs_pkg::BIT_CKSLO]),
    .sub_mode    (sub_mode),
    .subclk_tick (subclk_tick),
    .src_tick    (src_tick)
  );

  assign addr_ok   = hsel & hready & (htrans == sffs_pkg::HTRANS_NONSEQ);
  assign wr_go     = wr_reg;
  assign hreadyout = 1'b1;
  assign hresp     = sffs_pkg::HRESP_OKAY;
  assign hrdata    = hrdata_reg;
  assign txd       = txd_reg;
  assign sck       = sck_reg;
  assign irq       = |(stat_reg & mask_reg);
  assign tx_load   = wr_go & (addr_reg == sffs_pkg::OFS_TXD) & ~tx_busy_reg;
  assign tx_tick   = tx_busy_reg & src_tick & (tx_cnt_reg == period_reg - 1'b1);
  assign rx_tick   = (rx_state_reg == sffs_pkg::RX_BITS) & src_tick
                     & (rx_cnt_reg == period_reg - 1'b1);
  assign rx_last   = rx_idx_reg == (nbits(ffc_reg) + 4'd1
                     + {3'b000, par_on(ffc_reg) | mpb_on(ffc_reg)});

  // address phase capture
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      addr_reg <= 8'h00;
      wr_reg   <= 1'b0;
    end
    else
    begin
      addr_reg <= haddr[7:0];
      wr_reg   <= addr_ok & hwrite & (hsize == 3'b010);
    end
  end

  // read data registered for the data phase
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      hrdata_reg <= 32'h0000_0000;
    else if (addr_ok & ~hwrite)
    begin
      unique case (haddr[7:0])
        sffs_pkg::OFS_FFC:    hrdata_reg <= {24'h000000, ffc_reg};
        sffs_pkg::OFS_PERIOD:
          hrdata_reg <= {{(32-PERIOD_W){1'b0}}, period_reg};
        sffs_pkg::OFS_TXD:    hrdata_reg <= {23'h000000, txh_reg};
        sffs_pkg::OFS_RXD:    hrdata_reg <= {23'h000000, rxd_reg};
        sffs_pkg::OFS_STAT:   hrdata_reg <= {28'h0000000, stat_reg};
        sffs_pkg::OFS_MASK:   hrdata_reg <= {28'h0000000, mask_reg};
        sffs_pkg::OFS_BUSY:
          hrdata_reg <= {30'h00000000,
                         rx_state_reg == sffs_pkg::RX_BITS, tx_busy_reg};
        default:              hrdata_reg <= 32'h0000_0000;
      endcase
    end
  end

  // mode register, cleared on reset and standby
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      ffc_reg <= sffs_pkg::FFC_RESET;
    else if (standby)
      ffc_reg <= sffs_pkg::FFC_RESET;
    else if (wr_go & (addr_reg == sffs_pkg::OFS_FFC))
      ffc_reg <= hwdata[7:0];
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      period_reg <= PERIOD_W'(sffs_pkg::PERIOD_RESET);
      mask_reg   <= sffs_pkg::IRQ_RESET;
      txh_reg    <= sffs_pkg::TXD_RESET;
    end
    else if (standby)
    begin
      period_reg <= PERIOD_W'(sffs_pkg::PERIOD_RESET);
      mask_reg   <= sffs_pkg::IRQ_RESET;
      txh_reg    <= sffs_pkg::TXD_RESET;
    end
    else if (wr_go)
    begin
      if (addr_reg == sffs_pkg::OFS_PERIOD)
        period_reg <= hwdata[PERIOD_W-1:0];
      if (addr_reg == sffs_pkg::OFS_MASK)
        mask_reg <= hwdata[3:0];
      if (tx_load)
        txh_reg <= hwdata[8:0];
    end
  end

  // sticky events, cleared by a status read; a new event wins
  always_comb
  begin
    stat_next = stat_reg;
    if (addr_ok & ~hwrite & (haddr[7:0] == sffs_pkg::OFS_STAT))
      stat_next = sffs_pkg::IRQ_RESET;
    stat_next = stat_next | ev;
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      stat_reg <= sffs_pkg::IRQ_RESET;
    else if (standby)
      stat_reg <= sffs_pkg::IRQ_RESET;
    else
      stat_reg <= stat_next;
  end

  // transmitter
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      tx_busy_reg <= 1'b0;
      tx_sh_reg   <= '1;
      tx_left_reg <= 4'h0;
      tx_cnt_reg  <= '0;
    end
    else if (standby)
    begin
      tx_busy_reg <= 1'b0;
      tx_sh_reg   <= '1;
      tx_left_reg <= 4'h0;
      tx_cnt_reg  <= '0;
    end
    else if (tx_load)
    begin
      tx_busy_reg <= 1'b1;
      tx_sh_reg   <= frame(ffc_reg, hwdata[8:0]);
      tx_left_reg <= flen(ffc_reg);
      tx_cnt_reg  <= '0;
    end
    else if (tx_tick)
    begin
      tx_cnt_reg  <= '0;
      tx_sh_reg   <= {1'b1, tx_sh_reg[FRAME_W-1:1]};
      tx_left_reg <= tx_left_reg - 4'h1;
      tx_busy_reg <= tx_left_reg != 4'h1;
    end
    else if (tx_busy_reg & src_tick)
      tx_cnt_reg <= tx_cnt_reg + 1'b1;
  end

  // line outputs; clock low in first half of each synchronous bit
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      txd_reg <= 1'b1;
      sck_reg <= 1'b1;
    end
    else
    begin
      txd_reg <= tx_busy_reg ? tx_sh_reg[0] : 1'b1;
      sck_reg <= ~(tx_busy_reg & ffc_reg[sffs_pkg::BIT_COM]
                   & (tx_cnt_reg < (period_reg >> 1)));
    end
  end

  // receiver; async samples mid-bit, sync shares transmit timing
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      rx_state_reg <= sffs_pkg::RX_IDLE;
      rx_cnt_reg   <= '0;
      rx_idx_reg   <= 4'h0;
      rx_sh_reg    <= 10'h000;
      rxd_reg      <= 9'h000;
    end
    else if (standby)
    begin
      rx_state_reg <= sffs_pkg::RX_IDLE;
      rx_idx_reg   <= 4'h0;
      rxd_reg      <= 9'h000;
    end
    else if (ffc_reg[sffs_pkg::BIT_COM])
    begin
      rx_state_reg <= sffs_pkg::RX_IDLE;
      if (tx_load)
        rx_idx_reg <= 4'h0;
      else if (tx_tick)
      begin
        rx_sh_reg  <= {rxd, rx_sh_reg[9:1]};
        rx_idx_reg <= rx_idx_reg + 4'h1;
        if (tx_left_reg == 4'h1)
          rxd_reg <= {1'b0, rxd, rx_sh_reg[9:3]};
      end
    end
    else
    begin
      unique case (rx_state_reg)
        sffs_pkg::RX_IDLE:
          if (!rxd)
          begin
            rx_state_reg <= sffs_pkg::RX_BITS;
            rx_cnt_reg   <= period_reg >> 1;
            rx_idx_reg   <= 4'h0;
          end
        sffs_pkg::RX_BITS:
          if (rx_tick)
          begin
            rx_cnt_reg <= '0;
            rx_idx_reg <= rx_idx_reg + 4'h1;
            if (rx_idx_reg == 4'h0 && rxd)
              rx_state_reg <= sffs_pkg::RX_IDLE;
            else if (rx_last)
            begin
              rx_state_reg <= sffs_pkg::RX_IDLE;
              rxd_reg <= {mpb_on(ffc_reg) & rx_sh_reg[nbits(ffc_reg)],
                          rx_sh_reg[7:0] & ((8'h01 << nbits(ffc_reg))
                          - 8'h01)};
            end
            else if (rx_idx_reg != 4'h0)
              rx_sh_reg[rx_idx_reg-4'h1] <= rxd;
          end
          else if (src_tick)
            rx_cnt_reg <= rx_cnt_reg + 1'b1;
      endcase
    end
  end

  // event pulses
  always_comb
  begin
    ev = 4'h0;
    ev[sffs_pkg::EV_TXDONE] = tx_tick & (tx_left_reg == 4'h1);
    if (ffc_reg[sffs_pkg::BIT_COM])
      ev[sffs_pkg::EV_RXFULL] = tx_tick & (tx_left_reg == 4'h1);
    else if (rx_tick & rx_last)
    begin
      ev[sffs_pkg::EV_RXFULL] = 1'b1;
      ev[sffs_pkg::EV_FRMERR] = ~rxd;
      ev[sffs_pkg::EV_PARERR] = par_on(ffc_reg)
        & (par_bit(ffc_reg, rx_sh_reg[7:0])
           != rx_sh_reg[nbits(ffc_reg)]);
    end
  end
endmodule
